// file: rtl/i2s_config_prescaler.v
// APB configuration and prescaler registers of the combined SPI and audio serial unit.
//
// Behaviour
// - Protocol bit: 0 SPI, 1 audio; change when off.
// - Role field selects slave/master, transmit/receive.
// - Frame sync length applies only in PCM.
// - Standard field selects Philips, left, right, PCM.
// - Idle clock level follows polarity bit.
// - Sample length 16/24/32; code 11 forbidden.
// - Channel length forced 32 unless 16-bit samples.
// - Master clock output enable gates master clock.
// - Divide by twice prescaler, plus one if odd.
// - Odd bit and prescaler act only as master.
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_defines.vh"
module i2s_config_prescaler #(
  parameter ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_WIDTH-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Decoded configuration towards the shift engine
  input wire spi_enabled,
  output reg audio_mode,
  output reg audio_active,
  output reg is_master,
  output reg is_transmit,
  output reg [1:0] framing_standard,
  output reg long_frame_sync,
  output reg [1:0] sample_length,
  output reg channel_is_32,
  // Clocks towards the pins
  input wire master_clock_in,
  output reg master_clock_out,
  output reg master_clock_out_enable,
  output reg bit_clock_out,
  output reg bit_clock_out_enable
);
  reg [15:0] audio_serial_config;
  reg [15:0] audio_clock_divider;
  reg [15:0] next_config;
  reg [15:0] next_divider;
  reg [15:0] write_value;
  reg mclk_meta;
  reg mclk_sync;
  wire access;
  wire hit_cfg;
  wire hit_div;
  wire cfg_enable;
  wire cfg_proto;
  wire [1:0] cfg_role;
  wire [1:0] cfg_std;
  wire [1:0] cfg_slen;
  wire running;
  wire master_run;
  wire [8:0] ratio;
  wire divided_clock;

  assign access = psel && penable;
  assign hit_cfg = paddr == `CFG_OFFSET;
  assign hit_div = paddr == `DIV_OFFSET;
  assign cfg_enable = audio_serial_config[`CFG_EN_BIT];
  assign cfg_proto = audio_serial_config[`CFG_PROTO_BIT];
  assign cfg_role = audio_serial_config[`CFG_ROLE_HI:`CFG_ROLE_LO];
  assign cfg_std = audio_serial_config[`CFG_STD_HI:`CFG_STD_LO];
  assign cfg_slen = audio_serial_config[`CFG_SLEN_HI:`CFG_SLEN_LO];
  assign running = cfg_proto && cfg_enable;
  assign master_run = running && cfg_role[1];
  // Twice the prescaler plus the odd bit; values below two are clamped to two.
  assign ratio = (audio_clock_divider[`DIV_LIN_HI:`DIV_LIN_LO] < `MIN_PRESCALER) ?
    {`MIN_PRESCALER, 1'b0} :
    {audio_clock_divider[`DIV_LIN_HI:`DIV_LIN_LO], audio_clock_divider[`DIV_ODD_BIT]};

  // Only the written lanes are replaced; reserved bits always stay zero.
  always @* begin
    write_value = 16'h0000;
    write_value[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
    write_value[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
    next_config = audio_serial_config;
    next_divider = audio_clock_divider;
    // A write lands only at the edge that completes the transfer, so a request held
    // through its wait state is applied once and the protocol lock sees the old enable.
    if (access && pready && pwrite && hit_cfg) begin
      next_config = (write_value & `CFG_WRITE_MASK) |
        (audio_serial_config & ~{{8{pstrb[1]}}, {8{pstrb[0]}}});
      // The protocol bit only moves while both SPI and audio are off.
      if (spi_enabled || cfg_enable) begin
        next_config[`CFG_PROTO_BIT] = audio_serial_config[`CFG_PROTO_BIT];
      end
      // Code 11 is refused so the engine never sees an undefined length.
      if (next_config[`CFG_SLEN_HI:`CFG_SLEN_LO] == `SLEN_BAD) begin
        next_config[`CFG_SLEN_HI:`CFG_SLEN_LO] = cfg_slen;
      end
    end
    if (access && pready && pwrite && hit_div) begin
      next_divider = (write_value & `DIV_WRITE_MASK) |
        (audio_clock_divider & ~{{8{pstrb[1]}}, {8{pstrb[0]}}} & `DIV_WRITE_MASK);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      audio_serial_config <= `CFG_RESET;
      audio_clock_divider <= `DIV_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      audio_serial_config <= next_config;
      audio_clock_divider <= next_divider;
      // One wait state: pready rises in the second access cycle.
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit_cfg && !hit_div;
      if (psel && !penable) begin
        if (paddr == `CFG_OFFSET) begin
          prdata <= {16'h0000, audio_serial_config};
        end else if (paddr == `DIV_OFFSET) begin
          prdata <= {16'h0000, audio_clock_divider};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // Decoded settings are registered so every output comes from a flip-flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      audio_mode <= 1'b0;
      audio_active <= 1'b0;
      is_master <= 1'b0;
      is_transmit <= 1'b0;
      framing_standard <= `STD_PHILIPS;
      long_frame_sync <= 1'b0;
      sample_length <= `SLEN_16;
      channel_is_32 <= 1'b0;
    end else begin
      audio_mode <= cfg_proto;
      audio_active <= running;
      is_master <= cfg_proto && cfg_role[1];
      is_transmit <= cfg_proto && !cfg_role[0];
      framing_standard <= cfg_std;
      long_frame_sync <= audio_serial_config[`CFG_FSYNC_BIT] && cfg_std == `STD_PCM;
      sample_length <= cfg_slen;
      channel_is_32 <= (cfg_slen != `SLEN_16) ||
        audio_serial_config[`CFG_CHLEN_BIT];
    end
  end

  // The master clock arrives from another domain and is synchronised first.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_meta <= 1'b0;
      mclk_sync <= 1'b0;
      master_clock_out <= 1'b0;
      master_clock_out_enable <= 1'b0;
      bit_clock_out <= 1'b0;
      bit_clock_out_enable <= 1'b0;
    end else begin
      mclk_meta <= master_clock_in;
      mclk_sync <= mclk_meta;
      master_clock_out_enable <= master_run && audio_clock_divider[`DIV_MCLK_BIT];
      master_clock_out <= master_run && audio_clock_divider[`DIV_MCLK_BIT] && mclk_sync;
      // Slaves receive the bit clock, so the pin is released.
      bit_clock_out_enable <= master_run;
      bit_clock_out <= master_run ? divided_clock :
        audio_serial_config[`CFG_IDLE_BIT];
    end
  end

  audio_bit_clock_divider #(
    .WIDTH(9)
  ) u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .run(master_run),
    .ratio(ratio),
    .idle_level(audio_serial_config[`CFG_IDLE_BIT]),
    .bit_clock(divided_clock)
  );
endmodule // i2s_config_prescaler
`default_nettype wire

// file: rtl/audio_serial_defines.vh
// Register map, field positions, codes and reset values of the audio serial configuration block.
`ifndef AUDIO_SERIAL_DEFINES_VH
`define AUDIO_SERIAL_DEFINES_VH

`define CFG_OFFSET 12'h01c
`define DIV_OFFSET 12'h020
`define CFG_RESET 16'h0000
`define DIV_RESET 16'h0002
`define CFG_WRITE_MASK 16'h0fbf
`define DIV_WRITE_MASK 16'h03ff

`define CFG_CHLEN_BIT 0
`define CFG_SLEN_LO 1
`define CFG_SLEN_HI 2
`define CFG_IDLE_BIT 3
`define CFG_STD_LO 4
`define CFG_STD_HI 5
`define CFG_FSYNC_BIT 7
`define CFG_ROLE_LO 8
`define CFG_ROLE_HI 9
`define CFG_EN_BIT 10
`define CFG_PROTO_BIT 11

`define DIV_LIN_LO 0
`define DIV_LIN_HI 7
`define DIV_ODD_BIT 8
`define DIV_MCLK_BIT 9

`define ROLE_SLAVE_TX 2'h0
`define ROLE_SLAVE_RX 2'h1
`define ROLE_MASTER_TX 2'h2
`define ROLE_MASTER_RX 2'h3
`define STD_PHILIPS 2'h0
`define STD_LEFT 2'h1
`define STD_RIGHT 2'h2
`define STD_PCM 2'h3
`define SLEN_16 2'h0
`define SLEN_24 2'h1
`define SLEN_32 2'h2
`define SLEN_BAD 2'h3
`define MIN_PRESCALER 8'h02

`endif

// file: rtl/audio_bit_clock_divider.v
// Divider that makes the serial bit clock from the peripheral clock.
`timescale 1ns/1ps
`default_nettype none
module audio_bit_clock_divider #(
  parameter WIDTH = 9
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire run,
  input wire [WIDTH-1:0] ratio,
  input wire idle_level,
  // Output
  output reg bit_clock
);
  reg [WIDTH-1:0] count;
  wire [WIDTH-1:0] half_low;
  wire [WIDTH-1:0] last;

  // Odd ratios give an idle-level phase one cycle shorter than the active phase.
  assign half_low = ratio >> 1;
  assign last = ratio - {{(WIDTH-1){1'b0}}, 1'b1};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      bit_clock <= 1'b0;
    end else if (!run) begin
      count <= {WIDTH{1'b0}};
      bit_clock <= idle_level;
    end else begin
      if (count >= last) begin
        count <= {WIDTH{1'b0}};
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      if (count >= last) begin
        bit_clock <= idle_level;
      end else if (count == half_low - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        bit_clock <= ~idle_level;
      end
    end
  end
endmodule // audio_bit_clock_divider
`default_nettype wire

// file: bench/i2s_config_props_properties.sv
// Bus handshake and decode properties of the audio serial configuration block.
`timescale 1ns/1ps
`default_nettype none
module i2s_config_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Decode
  input wire logic audio_mode,
  input wire logic audio_active,
  input wire logic is_master,
  input wire logic long_frame_sync,
  input wire logic [1:0] framing_standard,
  input wire logic [1:0] sample_length,
  input wire logic channel_is_32,
  input wire logic master_clock_out,
  input wire logic master_clock_out_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_one_wait_state: assert property ($rose(penable) && psel |=> s_answer)
    else $error("ready not one cycle after access start");
  chk_no_early_ready: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready outside second access cycle");
  chk_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_fsync_pcm_only: assert property (long_frame_sync |-> framing_standard == 2'h3)
    else $error("long sync outside pcm");
  chk_channel_forced: assert property (sample_length != 2'h0 |-> channel_is_32)
    else $error("channel not forced to 32");
  chk_sample_legal: assert property (sample_length != 2'h3)
    else $error("forbidden sample length");
  chk_active_needs_audio: assert property (audio_active |-> audio_mode)
    else $error("active in spi mode");
  chk_master_needs_audio: assert property (is_master |-> audio_mode)
    else $error("role used in spi mode");
  chk_mclk_gated: assert property (master_clock_out |-> master_clock_out_enable)
    else $error("master clock while disabled");
endmodule // i2s_config_props
bind i2s_config_prescaler i2s_config_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .audio_mode(audio_mode), .audio_active(audio_active), .is_master(is_master),
  .long_frame_sync(long_frame_sync), .framing_standard(framing_standard),
  .sample_length(sample_length), .channel_is_32(channel_is_32),
  .master_clock_out(master_clock_out), .master_clock_out_enable(master_clock_out_enable));
`default_nettype wire

// file: bench/audio_peer.sv
// Model of the external audio peer that supplies the master clock.
`timescale 1ns/1ps
`default_nettype none
module audio_peer (
  // Clocks from the block
  input wire logic bit_clock,
  input wire logic bit_clock_enable,
  // Clock to the block
  output logic master_clock
);
  // Unrelated to pclk so that the block's synchroniser sees real skew.
  initial begin
    master_clock = 1'b0;
    forever #7 master_clock = ~master_clock;
  end
endmodule // audio_peer
`default_nettype wire

// file: bench/i2s_config_prescaler_test.sv
// Self-checking bench of the audio serial configuration block.
`timescale 1ns/1ps
`default_nettype none
module i2s_config_prescaler_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, spi_enabled = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h3;
  logic pready, pslverr, audio_mode, audio_active, is_master, is_transmit, long_frame_sync;
  logic channel_is_32, mclk, mclk_out, mclk_oe, bclk, bclk_oe, e;
  logic [1:0] framing_standard, sample_length, k;
  int n_mismatch = 0, n_checks = 0, cyc = 0, n;
  logic [11:0] ra [0:5] = '{12'h01c, 12'h01c, 12'h020, 12'h01c, 12'h01c, 12'h030};
  logic [15:0] rd [0:5] = '{16'h0800, 16'h08bf, 16'h03ff, 16'h0f22, 16'h0722, 16'hffff};
  logic [15:0] rx [0:5] = '{16'h0800, 16'h08b9, 16'h03ff, 16'h0f22, 16'h0f22, 16'h0000};
  i2s_config_prescaler uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_enabled(spi_enabled), .audio_mode(audio_mode),
    .audio_active(audio_active), .is_master(is_master), .is_transmit(is_transmit),
    .framing_standard(framing_standard), .long_frame_sync(long_frame_sync),
    .sample_length(sample_length), .channel_is_32(channel_is_32), .master_clock_in(mclk),
    .master_clock_out(mclk_out), .master_clock_out_enable(mclk_oe),
    .bit_clock_out(bclk), .bit_clock_out_enable(bclk_oe));
  audio_peer peer (.bit_clock(bclk), .bit_clock_enable(bclk_oe), .master_clock(mclk));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (x !== g) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // The request stands until pready is seen high at a rising edge; the answer is taken
  // and the request released at that same edge, then decoded outputs are left to settle.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h01c, 32'h0);
    chk("config reset", 32'h0, r);
    apb(1'b0, 12'h020, 32'h0);
    chk("divider reset", 32'h2, r);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], {16'h0, rd[i]});
      apb(1'b0, ra[i], 32'h0);
      chk("readback", {16'h0, rx[i]}, r);
      chk("slave error", {31'h0, ra[i] == 12'h030}, {31'h0, e});
    end
    chk("decode", 32'h3a3, {22'h0, audio_mode, audio_active, is_master, is_transmit,
      framing_standard, long_frame_sync, sample_length, channel_is_32});
    apb(1'b1, 12'h01c, 32'h0800);
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      apb(1'b1, 12'h01c, 32'h0880 | i << 8 | i << 4 | i << 1);
      chk("roles", {24'h0, k[1], ~k[0], k, k == 2'h3, (k == 2'h3) ? 2'h2 : k, k != 2'h0},
        {24'h0, is_master, is_transmit, framing_standard, long_frame_sync, sample_length,
        channel_is_32});
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 12'h01c, 32'h0a00);
      apb(1'b1, 12'h020, j ? 32'h0303 : 32'h0204);
      apb(1'b1, 12'h01c, 32'h0e00);
      while (bclk !== 1'b1) @(negedge pclk);
      while (bclk !== 1'b0) @(negedge pclk);
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (bclk === 1'b0);
      do begin
        @(negedge pclk);
        n++;
      end while (bclk === 1'b1);
      chk("bit clock period", j ? 32'd7 : 32'd8, 32'(n));
      chk("clock enables", 32'h3, {30'h0, mclk_oe, bclk_oe});
      k = 2'h0;
      repeat (20) begin
        @(negedge pclk);
        k = k | {mclk_out, ~mclk_out};
      end
      chk("master clock toggles", 32'h3, {30'h0, k});
    end
    apb(1'b1, 12'h01c, 32'h0a00);
    apb(1'b1, 12'h01c, 32'h0a08);
    repeat (3) @(negedge pclk);
    chk("idle clock", 32'h8, {28'h0, bclk, bclk_oe, mclk_oe, mclk_out});
    @(posedge pclk);
    spi_enabled <= 1'b1;
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk("protocol lock", 32'h0800, r);
    give_verdict();
  end
endmodule // i2s_config_prescaler_test
`default_nettype wire
